//--- mai_regs.vh
// Constants for the multiplier access interlock
`ifndef MAI_REGS_VH
`define MAI_REGS_VH
// Instruction class codes
`define MAI_CLS_OTHER 3'h0
`define MAI_CLS_MACW 3'h1
`define MAI_CLS_STS_MEM 3'h2
`define MAI_CLS_LDS_REG 3'h3
`define MAI_CLS_LDS_MEM 3'h4
`define MAI_CLS_W 3
// Multiplier busy cycles after the final access of a word multiply-accumulate
`define MAI_MUL_TAIL 3'h2
// Extra state a store waits after the multiplier goes idle
`define MAI_STORE_EXTRA 3'h1
`define MAI_CNT_W 3
// Counter idle value and step
`define MAI_CNT_IDLE 3'h0
`define MAI_CNT_STEP 3'h1
`endif

//--- mai_interlock.v
// Multiplier access interlock for accumulator transfers after a word multiply-accumulate
//
// Contract
// - An accumulator store to memory gets an extra memory access stage that reads the multiplier and writes memory.
// - A store access stage meeting a busy multiplier stretches into one slot until one state after it finishes.
// - The store access stage competes with instruction fetch under the normal slot arbitration.
// - An accumulator load from a general register gets a memory access stage that reaches the multiplier.
// - A register-to-accumulator access stage meeting a busy multiplier is held as one slot until it ends.
// - The register-to-accumulator access stage competes with instruction fetch like any other access.
// - An accumulator load from memory gets a multiplier access stage stretched while the multiplier is busy.
// - The memory-to-accumulator access stage competes with instruction fetch under the usual arbitration.
`timescale 1ns/1ps
`default_nettype none
`include "mai_regs.vh"
module mai_interlock
(
  input wire clk,
  input wire rst_n,
  // Class of the instruction entering the execute stage
  input wire ex_valid,
  input wire [`MAI_CLS_W-1:0] ex_class,
  // Word multiply-accumulate finishing its final access this cycle
  input wire mac_final_access,
  // Instruction fetch wants the bus this cycle
  input wire fetch_req,
  // Access stage of this block is active and wants the bus / multiplier
  output wire acc_stage_active,
  output wire acc_bus_req,
  output wire acc_mul_access,
  output wire acc_mem_write,
  output wire acc_mem_read,
  // Slot completes this cycle
  output wire acc_done,
  // Hold of decode and execute stages
  output wire stall_decode_execute,
  // Multiplier busy indication
  output reg multiplier_busy_stage_reg,
  output reg [`MAI_CLS_W-1:0] acc_class_reg
);

// ****************************************
// State
// ****************************************
localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_TAIL = 2'h2;
localparam ST_ACC = 2'h3;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [`MAI_CNT_W-1:0] mul_cnt_reg;
reg [`MAI_CNT_W-1:0] mul_cnt_next;
reg [`MAI_CNT_W-1:0] tail_cnt_reg;
reg [`MAI_CNT_W-1:0] tail_cnt_next;
reg [`MAI_CLS_W-1:0] acc_class_next;
reg multiplier_busy_stage_next;
reg stage_active_comb;
reg bus_req_comb;
reg done_comb;
wire mul_busy;
wire start;
wire store_sel;
wire load_mem_sel;

// ****************************************
// Class decode
// ****************************************
function is_store;
  input [`MAI_CLS_W-1:0] c;
  begin
    is_store = (c == `MAI_CLS_STS_MEM);
  end
endfunction

function is_load_reg;
  input [`MAI_CLS_W-1:0] c;
  begin
    is_load_reg = (c == `MAI_CLS_LDS_REG);
  end
endfunction

function is_load_mem;
  input [`MAI_CLS_W-1:0] c;
  begin
    is_load_mem = (c == `MAI_CLS_LDS_MEM);
  end
endfunction

function is_acc_class;
  input [`MAI_CLS_W-1:0] c;
  begin
    is_acc_class = is_store(c) || is_load_reg(c) || is_load_mem(c);
  end
endfunction

// Saturates at idle so a stray step can never wrap into a false busy
function [`MAI_CNT_W-1:0] cnt_down;
  input [`MAI_CNT_W-1:0] v;
  begin
    if (v == `MAI_CNT_IDLE)
      cnt_down = `MAI_CNT_IDLE;
    else
      cnt_down = v - `MAI_CNT_STEP;
  end
endfunction

// ****************************************
// Selects
// ****************************************
assign mul_busy = (mul_cnt_reg != `MAI_CNT_IDLE);
assign start = ex_valid && is_acc_class(ex_class);
assign store_sel = is_store(acc_class_reg);
assign load_mem_sel = is_load_mem(acc_class_reg);

// ****************************************
// Multiplier tail counter
// ****************************************
// Busy runs for a fixed tail after the final access, regardless of slots
always @*
begin
  mul_cnt_next = cnt_down(mul_cnt_reg);
  if (mac_final_access)
    mul_cnt_next = `MAI_MUL_TAIL;
  multiplier_busy_stage_next = (mul_cnt_next != `MAI_CNT_IDLE);
end

// ****************************************
// Access stage sequencer
// ****************************************
always @*
begin
  state_next = state_reg;
  acc_class_next = acc_class_reg;
  tail_cnt_next = tail_cnt_reg;
  case (state_reg)
    ST_IDLE:
    begin
      if (start)
      begin
        acc_class_next = ex_class;
        state_next = ST_WAIT;
      end
    end
    ST_WAIT:
    begin
      if (!mul_busy && !mac_final_access)
      begin
        if (store_sel)
        begin
          tail_cnt_next = `MAI_CNT_STEP;
          state_next = ST_TAIL;
        end
        else
          state_next = ST_ACC;
      end
    end
    ST_TAIL:
    begin
      if (tail_cnt_reg >= `MAI_STORE_EXTRA)
        state_next = ST_ACC;
      else
        tail_cnt_next = tail_cnt_reg + `MAI_CNT_STEP;
    end
    ST_ACC:
    begin
      // fetch wins slot split, access waits
      if (!fetch_req)
        state_next = ST_IDLE;
    end
    default:
      state_next = ST_IDLE;
  endcase
end

// ****************************************
// Registers
// ****************************************
always @(posedge clk)
begin
  if (!rst_n)
    state_reg <= ST_IDLE;
  else
    state_reg <= state_next;
end

always @(posedge clk)
begin
  if (!rst_n)
    mul_cnt_reg <= `MAI_CNT_IDLE;
  else
    mul_cnt_reg <= mul_cnt_next;
end

always @(posedge clk)
begin
  if (!rst_n)
    tail_cnt_reg <= `MAI_CNT_IDLE;
  else
    tail_cnt_reg <= tail_cnt_next;
end

always @(posedge clk)
begin
  if (!rst_n)
    acc_class_reg <= `MAI_CLS_OTHER;
  else
    acc_class_reg <= acc_class_next;
end

always @(posedge clk)
begin
  if (!rst_n)
    multiplier_busy_stage_reg <= 1'b0;
  else
    multiplier_busy_stage_reg <= multiplier_busy_stage_next;
end

// ****************************************
// Output decode
// ****************************************
// Fetch takes the bus first, so the slot only closes in a cycle without a fetch
always @*
begin
  stage_active_comb = 1'b1;
  bus_req_comb = 1'b0;
  done_comb = 1'b0;
  case (state_reg)
    ST_IDLE:
      stage_active_comb = 1'b0;
    ST_WAIT:
      bus_req_comb = 1'b0;
    ST_TAIL:
      bus_req_comb = 1'b0;
    ST_ACC:
    begin
      bus_req_comb = 1'b1;
      done_comb = !fetch_req;
    end
    default:
      stage_active_comb = 1'b0;
  endcase
end

// ****************************************
// Outputs
// ****************************************
assign acc_stage_active = stage_active_comb;
assign acc_bus_req = bus_req_comb;
assign acc_done = done_comb;
assign acc_mul_access = done_comb;
// store writes memory in same stage
assign acc_mem_write = done_comb && store_sel;
// load from memory reads memory in same stage
assign acc_mem_read = done_comb && load_mem_sel;
assign stall_decode_execute = stage_active_comb && !done_comb;

endmodule
`default_nettype wire

//--- mai_props.sv
// Checker for the multiplier access interlock ports
`timescale 1ns/1ps
`default_nettype none
`include "mai_regs.vh"
module mai_props
(
  input wire clk,
  input wire rst_n,
  input wire ex_valid,
  input wire [`MAI_CLS_W-1:0] ex_class,
  input wire fetch_req,
  input wire acc_stage_active,
  input wire acc_bus_req,
  input wire acc_mul_access,
  input wire acc_mem_write,
  input wire acc_mem_read,
  input wire acc_done,
  input wire stall_decode_execute,
  input wire multiplier_busy_stage_reg,
  input wire [`MAI_CLS_W-1:0] acc_class_reg
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_store_write: assert property (acc_mem_write |-> acc_done && acc_class_reg == `MAI_CLS_STS_MEM)
    else $error("write");
  chk_store_tail: assert property (acc_done && acc_class_reg == `MAI_CLS_STS_MEM
    |-> !$past(multiplier_busy_stage_reg)) else $error("tail");
  chk_fetch_first: assert property (fetch_req && acc_bus_req
    |-> !acc_done ##1 acc_bus_req) else $error("fetch");
  chk_mul_access: assert property (acc_done |-> acc_mul_access && acc_bus_req) else $error("mul");
  chk_busy_hold: assert property (multiplier_busy_stage_reg |-> !acc_done) else $error("busy");
  chk_load_read: assert property (acc_mem_read |-> acc_done && acc_class_reg == `MAI_CLS_LDS_MEM)
    else $error("read");
  chk_stall_hold: assert property (acc_stage_active && !acc_done |-> stall_decode_execute) else $error("stall");
  chk_start_take: assert property (ex_valid && !acc_stage_active && (ex_class == `MAI_CLS_STS_MEM
    || ex_class == `MAI_CLS_LDS_REG || ex_class == `MAI_CLS_LDS_MEM) |=> acc_stage_active) else $error("start");
endmodule
bind mai_interlock mai_props mai_props_i (.*);
`default_nettype wire

//--- tb_multiplier_access_interlock.sv
// Testbench for the multiplier access interlock
`timescale 1ns/1ps
`default_nettype none
module tb_multiplier_access_interlock;
  reg clk = 0, rst_n = 0, ex_valid = 0, mac_final_access = 0, fetch_req = 0;
  reg [2:0] ex_class = 0;
  wire act, brq, mul, wr, rd, done, stall, busy;
  wire [2:0] cls;
  integer error_cnt = 0, n_checks = 0, i, c, b, f, n, a;
  int exp_q[$];
  always #25 clk = ~clk;
  mai_interlock mai_interlock_i (.clk(clk), .rst_n(rst_n), .ex_valid(ex_valid), .ex_class(ex_class),
    .mac_final_access(mac_final_access), .fetch_req(fetch_req), .acc_stage_active(act), .acc_bus_req(brq),
    .acc_mul_access(mul), .acc_mem_write(wr), .acc_mem_read(rd), .acc_done(done),
    .stall_decode_execute(stall), .multiplier_busy_stage_reg(busy), .acc_class_reg(cls));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD %s exp %0h got %0h", nm, e, s);
    end
  end
  endtask
  task conclude;
  begin
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Each transfer is short, so a few thousand cycles is ample
  initial
  begin
    #300000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial
  begin
    i = $urandom(32'hA8D105CB);
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk("idle", {act, stall, done, busy}, 32'h0);
    for (i = 0; i < 40; i = i + 1)
    begin
      c = $urandom % 5;
      b = $urandom % 2;
      f = $urandom % 5;
      @(posedge clk);
      ex_valid <= 1;
      ex_class <= c[2:0];
      mac_final_access <= b;
      @(posedge clk);
      ex_valid <= 0;
      mac_final_access <= 0;
      if (c < 2)
      begin
        // Other classes pass straight through, with no access stage
        @(posedge clk);
        chk("ignore", {act, stall}, 32'h0);
        chk("busy", busy, b);
      end
      else
      begin
        // Model: a wait state, two busy states and the store's extra state before the slot
        a = (c == 2 ? 3 : 2) + 2 * b;
        // Fetch keeps the bus for its whole request, so the slot closes no earlier
        exp_q.push_back(a > f + 1 ? a : f + 1);
        fetch_req <= (f > 0);
        n = 0;
        while (done !== 1'b1 && n < 30)
        begin
          @(posedge clk);
          n = n + 1;
          if (n == f)
            fetch_req <= 0;
          chk("busy", busy, b && n < 3);
          chk("stall", stall, n < exp_q[0]);
          chk("bus", brq, n >= a);
        end
        chk("latency", n, exp_q.pop_front());
        chk("mul", mul, 1);
        chk("write", wr, c == 2);
        chk("read", rd, c == 4);
        chk("class", cls, c);
      end
    end
    conclude;
  end
endmodule
`default_nettype wire
